// >>> src/sfb_consts.svh
// constants for the serial boot command handler
`ifndef SFB_CONSTS_SVH
`define SFB_CONSTS_SVH
`define MATCH_BYTE   8'h5A
`define BAUD_RESET   8'h28
`define ERR_LEAD_A   8'hA1
`define ERR_LEAD_B   8'hA3
`define ERR_BAUD     8'h62
`define ERR_CMD      8'h63
`define CMD_ERASE    8'hF0
`define CMD_WRITE    8'h30
`define CMD_RAM      8'h60
`define CMD_SUM      8'h90
`define CMD_ID       8'hC0
`define CMD_STATUS   8'hC3
`define CMD_PROTECT  8'hFA
`define FLASH_FIRST  16'hC000
`define FLASH_LAST   16'hFFFF
`define TOP_FIRST    16'hFFE0
`define SECT_FIRST   4'hC
`define SECT_LAST    4'hF
`define REC_DATA     8'h00
`define REC_END      8'h01
`define ERR_LEN      4'h9
`define ID_LEN       4'hD
`define STAT_LEN     4'h7
`define SUM_LEN      4'h2
`define ID_HDR       8'h3A
`define STAT_HDR     8'h3B
`define BLANK_CODE   8'hFF
`define PROT_CODE    8'h01
`endif

// >>> src/sfb_pkg.sv
// types shared by the serial boot command handler
package sfb_pkg;
  typedef enum logic [3:0] {
    S_MATCH = 4'h0, S_BAUD = 4'h1, S_CMD = 4'h2, S_SEND = 4'h3,
    S_DISP = 4'h4, S_PWA = 4'h5, S_BLANK = 4'h6, S_PCNT = 4'h7,
    S_PWRX = 4'h8, S_PWCHK = 4'h9, S_ERX = 4'hA, S_EWAIT = 4'hB,
    S_SUM = 4'hC, S_REC = 4'hD, S_FWR = 4'hE, S_HALT = 4'hF
  } state_e;
  typedef enum logic [2:0] {
    K_ECHO = 3'h0, K_EBAUD = 3'h1, K_ECMD = 3'h2, K_SUM = 3'h3,
    K_ID = 3'h4, K_STAT = 3'h5
  } kind_e;
  typedef struct packed {
    logic        run;
    logic        pend;
    logic        done;
    logic [15:0] addr;
    logic [15:0] last;
    logic [15:0] sum;
    logic        ones;
  } scan_s;
  typedef struct packed {
    state_e      st;
    state_e      post;
    kind_e       kind;
    logic [3:0]  idx;
    logic        txv;
    logic [7:0]  txd;
    logic [7:0]  cmd;
    logic [7:0]  baud;
    logic        prot;
    logic        pinit;
    logic        blank;
    logic        jump;
    logic [1:0]  ai;
    logic [15:0] pcnt_a;
    logic [15:0] pcmp_a;
    logic [7:0]  pn;
    logic [7:0]  pi;
    logic [7:0]  pbyte;
    logic [8:0]  ri;
    logic [7:0]  rlen;
    logic [7:0]  rtype;
    logic [15:0] raddr;
    logic [7:0]  rcs;
    logic [15:0] sum;
    logic        first;
    logic [15:0] jaddr;
    logic        fwr;
    logic        fer;
    logic        erall;
    logic [3:0]  es;
    logic [3:0]  ee;
    logic        rwr;
    logic [15:0] wa;
    logic [7:0]  wd;
    logic        armed;
    logic        sgo;
    logic [15:0] sfirst;
    logic [15:0] slast;
  } hs_s;
endpackage

// >>> src/flash_scan.sv
// sequential flash reader that sums bytes and checks for all ones
`timescale 1ns/100ps
`default_nettype none
module flash_scan (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // request
  input  wire logic        go,
  input  wire logic [15:0] first,
  input  wire logic [15:0] last,
  // result
  output logic             done,
  output logic [15:0]      sum,
  output logic             all_ones,
  // flash read port, data returns one cycle after the strobe
  output logic             mem_rd,
  output logic [15:0]      mem_addr,
  input  wire logic [7:0]  mem_data
);
  sfb_pkg::scan_s cur;
  sfb_pkg::scan_s nxt;

  always_comb begin
    nxt = cur;
    nxt.done = cur.pend & ~cur.run;
    nxt.pend = cur.run;
    if (cur.pend) begin
      nxt.sum = cur.sum + {8'h00, mem_data};
      nxt.ones = cur.ones & (mem_data == 8'hFF);
    end
    if (cur.run) begin
      if (cur.addr == cur.last) begin
        nxt.run = 1'b0;
      end else begin
        nxt.addr = cur.addr + 16'h0001;
      end
    end else if (go && !cur.pend) begin
      nxt.run = 1'b1;
      nxt.addr = first;
      nxt.last = last;
      nxt.sum = 16'h0000;
      nxt.ones = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign done     = cur.done;
  assign sum      = cur.sum;
  assign all_ones = cur.ones;
  assign mem_rd   = cur.run;
  assign mem_addr = cur.addr;
endmodule
`default_nettype wire

// >>> src/sfb_handler.sv
// serial boot command handler: handshake, password, erase, write, RAM load, reports
`timescale 1ns/100ps
`default_nettype none
`include "sfb_consts.svh"
module sfb_handler #(
  parameter logic [7:0] ID_CODE = 8'h5C  // arbitrary product code value
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // read protection strap, caught once after reset
  input  wire logic        read_prot_init,
  // received bytes from the serial receiver
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_error,
  output logic             rx_ready,
  // bytes to the serial transmitter
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  // link settings and condition
  output logic [7:0]       baud_code,
  output logic             read_prot,
  output logic             halted,
  // flash read port
  output logic             flash_rd,
  output logic [15:0]      flash_rd_addr,
  input  wire logic [7:0]  flash_rd_data,
  // flash program and erase port
  output logic             flash_wr,
  output logic [15:0]      flash_wr_addr,
  output logic [7:0]       flash_wr_data,
  output logic             flash_erase,
  output logic             flash_erase_all,
  output logic [3:0]       erase_first,
  output logic [3:0]       erase_last,
  input  wire logic        flash_busy,
  // internal RAM load port and branch
  output logic             ram_wr,
  output logic [15:0]      ram_addr,
  output logic [7:0]       ram_wr_data,
  output logic             jump_valid,
  output logic [15:0]      jump_addr
);
  sfb_pkg::hs_s cur;
  sfb_pkg::hs_s nxt;
  logic        scan_done;
  logic [15:0] scan_sum;
  logic        scan_ones;

  flash_scan u_scan (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .go       (cur.sgo),
    .first    (cur.sfirst),
    .last     (cur.slast),
    .done     (scan_done),
    .sum      (scan_sum),
    .all_ones (scan_ones),
    .mem_rd   (flash_rd),
    .mem_addr (flash_rd_addr),
    .mem_data (flash_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic baud_ok(input logic [7:0] b);
    return b == 8'h04 || b == 8'h05 || b == 8'h06 || b == 8'h07 ||
           b == 8'h0A || b == 8'h18 || b == 8'h28;
  endfunction

  function automatic logic cmd_ok(input logic [7:0] c);
    return c == `CMD_ERASE || c == `CMD_WRITE || c == `CMD_RAM || c == `CMD_SUM ||
           c == `CMD_ID || c == `CMD_STATUS || c == `CMD_PROTECT;
  endfunction

  function automatic logic [3:0] kind_len(input sfb_pkg::kind_e k);
    logic [3:0] n;
    n = 4'h1;
    if (k == sfb_pkg::K_EBAUD || k == sfb_pkg::K_ECMD) begin
      n = `ERR_LEN;
    end else if (k == sfb_pkg::K_SUM) begin
      n = `SUM_LEN;
    end else if (k == sfb_pkg::K_ID) begin
      n = `ID_LEN;
    end else if (k == sfb_pkg::K_STAT) begin
      n = `STAT_LEN;
    end
    return n;
  endfunction

  // byte idx of the answer of kind k
  function automatic logic [7:0] tx_pick(input sfb_pkg::hs_s s, input sfb_pkg::kind_e k,
                                         input logic [3:0] i);
    logic [7:0] b;
    b = 8'h00;
    case (k)
      sfb_pkg::K_ECHO: b = s.cmd;
      sfb_pkg::K_EBAUD, sfb_pkg::K_ECMD: begin
        if (i < 4'h3) begin
          b = `ERR_LEAD_A;
        end else if (i < 4'h6) begin
          b = `ERR_LEAD_B;
        end else begin
          b = (k == sfb_pkg::K_EBAUD) ? `ERR_BAUD : `ERR_CMD;
        end
      end
      sfb_pkg::K_SUM: b = (i == 4'h0) ? s.sum[15:8] : s.sum[7:0];
      sfb_pkg::K_ID: begin
        // ROM range travels as first and last address, high byte first
        if (i == 4'h0) b = `ID_HDR;
        else if (i == 4'h1) b = ID_CODE;
        else if (i == 4'h2) b = 8'(`FLASH_FIRST >> 8);
        else if (i == 4'h3) b = 8'(`FLASH_FIRST & 16'h00FF);
        else if (i == 4'h4) b = 8'(`FLASH_LAST >> 8);
        else if (i == 4'h5) b = 8'(`FLASH_LAST & 16'h00FF);
      end
      sfb_pkg::K_STAT: begin
        if (i == 4'h0) b = `STAT_HDR;
        else if (i == 4'h1) b = s.blank ? `BLANK_CODE : 8'h00;
        else if (i == 4'h2) b = s.prot ? `PROT_CODE : 8'h00;
      end
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  function automatic sfb_pkg::hs_s send(input sfb_pkg::hs_s s, input sfb_pkg::kind_e k,
                                        input sfb_pkg::state_e p);
    sfb_pkg::hs_s r;
    r = s;
    r.st = sfb_pkg::S_SEND;
    r.kind = k;
    r.post = p;
    r.idx = 4'h0;
    r.txv = 1'b1;
    r.txd = tx_pick(s, k, 4'h0);
    return r;
  endfunction

  function automatic sfb_pkg::hs_s scan(input sfb_pkg::hs_s s, input logic [15:0] a,
                                        input logic [15:0] z, input sfb_pkg::state_e p);
    sfb_pkg::hs_s r;
    r = s;
    r.sgo = 1'b1;
    r.sfirst = a;
    r.slast = z;
    r.st = p;
    return r;
  endfunction

  // password stage over: go on to the operation itself
  function automatic sfb_pkg::hs_s after_pw(input sfb_pkg::hs_s s);
    sfb_pkg::hs_s r;
    r = s;
    r.ri = 9'h000;
    r.rcs = 8'h00;
    r.sum = 16'h0000;
    r.first = 1'b1;
    r.st = (s.cmd == `CMD_ERASE) ? sfb_pkg::S_ERX : sfb_pkg::S_REC;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic       take;
  logic [7:0] ncs;

  always_comb begin
    rx_ready = cur.st == sfb_pkg::S_MATCH || cur.st == sfb_pkg::S_BAUD ||
               cur.st == sfb_pkg::S_CMD || cur.st == sfb_pkg::S_PWA ||
               cur.st == sfb_pkg::S_PWRX || cur.st == sfb_pkg::S_ERX ||
               cur.st == sfb_pkg::S_REC;
    rx_ready = rx_ready && cur.pinit;
    take = rx_valid && rx_ready;
    ncs = cur.rcs + rx_data;
    nxt = cur;
    nxt.sgo = 1'b0;
    nxt.fwr = 1'b0;
    nxt.fer = 1'b0;
    nxt.rwr = 1'b0;
    nxt.jump = 1'b0;
    if (!cur.pinit) begin
      nxt.pinit = 1'b1;
      nxt.prot = read_prot_init;
    end
    case (cur.st)
      sfb_pkg::S_MATCH: begin
        if (take && !rx_error && rx_data == `MATCH_BYTE) begin
          nxt.cmd = rx_data;
          nxt = send(nxt, sfb_pkg::K_ECHO, sfb_pkg::S_BAUD);
        end
      end
      sfb_pkg::S_BAUD: begin
        if (take) begin
          nxt.cmd = rx_data;
          if (!rx_error && baud_ok(rx_data)) begin
            nxt = send(nxt, sfb_pkg::K_ECHO, sfb_pkg::S_CMD);
          end else begin
            nxt = send(nxt, sfb_pkg::K_EBAUD, sfb_pkg::S_HALT);
          end
        end
      end
      sfb_pkg::S_CMD: begin
        if (take) begin
          nxt.cmd = rx_data;
          if (!rx_error && cmd_ok(rx_data)) begin
            nxt = send(nxt, sfb_pkg::K_ECHO, sfb_pkg::S_DISP);
          end else begin
            nxt = send(nxt, sfb_pkg::K_ECMD, sfb_pkg::S_HALT);
          end
        end
      end
      sfb_pkg::S_SEND: begin
        if (tx_ready) begin
          if (cur.idx + 4'h1 == kind_len(cur.kind)) begin
            nxt.txv = 1'b0;
            nxt.st = cur.post;
            // new rate only after its echo has gone out
            if (cur.kind == sfb_pkg::K_ECHO && cur.post == sfb_pkg::S_CMD) begin
              nxt.baud = cur.cmd;
            end
          end else begin
            nxt.idx = cur.idx + 4'h1;
            nxt.txd = tx_pick(cur, cur.kind, cur.idx + 4'h1);
          end
        end
      end
      sfb_pkg::S_DISP: begin
        nxt.ai = 2'h0;
        nxt.st = sfb_pkg::S_PWA;
        if (cur.cmd == `CMD_WRITE || cur.cmd == `CMD_RAM) begin
          if (cur.prot) nxt.st = sfb_pkg::S_HALT;
        end else if (cur.cmd == `CMD_SUM) begin
          nxt = scan(nxt, `FLASH_FIRST, `FLASH_LAST, sfb_pkg::S_SUM);
        end else if (cur.cmd == `CMD_ID) begin
          nxt = send(nxt, sfb_pkg::K_ID, sfb_pkg::S_CMD);
        end else if (cur.cmd == `CMD_STATUS) begin
          nxt = scan(nxt, `TOP_FIRST, `FLASH_LAST, sfb_pkg::S_BLANK);
        end else if (cur.cmd == `CMD_PROTECT) begin
          nxt.prot = 1'b1;
          nxt.st = sfb_pkg::S_CMD;
        end
      end
      sfb_pkg::S_PWA: begin
        if (take) begin
          if (rx_error) begin
            nxt.st = sfb_pkg::S_HALT;
          end else begin
            // count address then compare address, high byte first, no answer
            if (!cur.ai[1]) nxt.pcnt_a = {cur.pcnt_a[7:0], rx_data};
            else nxt.pcmp_a = {cur.pcmp_a[7:0], rx_data};
            nxt.ai = cur.ai + 2'h1;
            if (cur.ai == 2'h3) begin
              nxt = scan(nxt, `TOP_FIRST, `FLASH_LAST, sfb_pkg::S_BLANK);
            end
          end
        end
      end
      sfb_pkg::S_BLANK: begin
        if (scan_done) begin
          nxt.blank = scan_ones;
          if (cur.cmd == `CMD_STATUS) begin
            nxt = send(nxt, sfb_pkg::K_STAT, sfb_pkg::S_CMD);
          end else if (scan_ones) begin
            nxt = after_pw(nxt);
          end else begin
            nxt = scan(nxt, cur.pcnt_a, cur.pcnt_a, sfb_pkg::S_PCNT);
          end
        end
      end
      sfb_pkg::S_PCNT: begin
        if (scan_done) begin
          nxt.pn = scan_sum[7:0];
          nxt.pi = 8'h00;
          nxt.st = (scan_sum[7:0] == 8'h00) ? sfb_pkg::S_HALT : sfb_pkg::S_PWRX;
        end
      end
      sfb_pkg::S_PWRX: begin
        if (take) begin
          if (rx_error) begin
            nxt.st = sfb_pkg::S_HALT;
          end else begin
            nxt.pbyte = rx_data;
            nxt = scan(nxt, cur.pcmp_a + {8'h00, cur.pi}, cur.pcmp_a + {8'h00, cur.pi},
                       sfb_pkg::S_PWCHK);
          end
        end
      end
      sfb_pkg::S_PWCHK: begin
        if (scan_done) begin
          nxt.pi = cur.pi + 8'h01;
          if (scan_sum[7:0] != cur.pbyte) begin
            nxt.st = sfb_pkg::S_HALT;
          end else if (cur.pi + 8'h01 == cur.pn) begin
            nxt = after_pw(nxt);
          end else begin
            nxt.st = sfb_pkg::S_PWRX;
          end
        end
      end
      sfb_pkg::S_ERX: begin
        if (take) begin
          nxt.es = rx_data[7:4];
          nxt.ee = rx_data[3:0];
          nxt.erall = rx_data[7:4] == `SECT_FIRST && rx_data[3:0] == `SECT_LAST;
          nxt.armed = 1'b0;
          if (rx_error || rx_data[7:4] < `SECT_FIRST || rx_data[3:0] < rx_data[7:4]) begin
            nxt.st = sfb_pkg::S_HALT;
          end else if (cur.prot && !nxt.erall) begin
            nxt.st = sfb_pkg::S_HALT;
          end else begin
            nxt.fer = 1'b1;
            nxt.st = sfb_pkg::S_EWAIT;
          end
        end
      end
      sfb_pkg::S_EWAIT: begin
        nxt.armed = 1'b1;
        if (cur.armed && !flash_busy) begin
          if (cur.erall) nxt.prot = 1'b0;
          nxt = scan(nxt, `FLASH_FIRST, `FLASH_LAST, sfb_pkg::S_SUM);
        end
      end
      sfb_pkg::S_SUM: begin
        if (scan_done) begin
          nxt.sum = scan_sum;
          nxt = send(nxt, sfb_pkg::K_SUM, sfb_pkg::S_CMD);
        end
      end
      sfb_pkg::S_REC: begin
        if (take) begin
          nxt.ri = cur.ri + 9'h001;
          nxt.rcs = ncs;
          if (rx_error) begin
            nxt.st = sfb_pkg::S_HALT;
          end else if (cur.ri == 9'h000) begin
            nxt.rlen = rx_data;
          end else if (cur.ri == 9'h001) begin
            nxt.raddr[15:8] = rx_data;
          end else if (cur.ri == 9'h002) begin
            nxt.raddr[7:0] = rx_data;
          end else if (cur.ri == 9'h003) begin
            nxt.rtype = rx_data;
          end else if (cur.ri < {1'b0, cur.rlen} + 9'h004) begin
            if (cur.rtype == `REC_DATA) begin
              nxt.wa = cur.raddr + {7'h00, cur.ri} - 16'h0004;
              nxt.wd = rx_data;
              if (cur.cmd == `CMD_WRITE) begin
                nxt.fwr = 1'b1;
                nxt.armed = 1'b0;
                nxt.st = sfb_pkg::S_FWR;
              end else begin
                nxt.rwr = 1'b1;
                nxt.sum = cur.sum + {8'h00, rx_data};
                if (cur.first) nxt.jaddr = cur.raddr;
                nxt.first = 1'b0;
              end
            end
          end else if (ncs != 8'h00) begin
            nxt.st = sfb_pkg::S_HALT;
          end else if (cur.rtype == `REC_END) begin
            if (cur.cmd == `CMD_WRITE) begin
              nxt = scan(nxt, `FLASH_FIRST, `FLASH_LAST, sfb_pkg::S_SUM);
            end else begin
              nxt = send(nxt, sfb_pkg::K_SUM, sfb_pkg::S_PCNT);
              nxt.post = sfb_pkg::S_HALT;
              nxt.jump = 1'b0;
              nxt.pn = 8'hFF;
            end
          end else begin
            nxt.ri = 9'h000;
            nxt.rcs = 8'h00;
          end
        end
      end
      sfb_pkg::S_FWR: begin
        nxt.armed = 1'b1;
        if (cur.armed && !flash_busy) nxt.st = sfb_pkg::S_REC;
      end
      default: begin
        nxt.txv = 1'b0;
      end
    endcase
    // RAM load leaves the handler right after its checksum
    if (cur.st == sfb_pkg::S_SEND && nxt.st == sfb_pkg::S_HALT &&
        cur.kind == sfb_pkg::K_SUM && cur.cmd == `CMD_RAM) begin
      nxt.jump = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur <= '0;
      cur.st <= sfb_pkg::S_MATCH;
      cur.post <= sfb_pkg::S_MATCH;
      cur.baud <= `BAUD_RESET;
    end else begin
      cur <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign tx_valid        = cur.txv;
  assign tx_data         = cur.txd;
  assign baud_code       = cur.baud;
  assign read_prot       = cur.prot;
  assign halted          = cur.st == sfb_pkg::S_HALT;
  assign flash_wr        = cur.fwr;
  assign flash_wr_addr   = cur.wa;
  assign flash_wr_data   = cur.wd;
  assign flash_erase     = cur.fer;
  assign flash_erase_all = cur.erall;
  assign erase_first     = cur.es;
  assign erase_last      = cur.ee;
  assign ram_wr          = cur.rwr;
  assign ram_addr        = cur.wa;
  assign ram_wr_data     = cur.wd;
  assign jump_valid      = cur.jump;
  assign jump_addr       = cur.jaddr;
endmodule
`default_nettype wire

// >>> verif/flash_model.sv
// behavioural flash array behind the handler's read and program ports
`timescale 1ns/100ps
`default_nettype none
module flash_model (
  // clock
  input  wire logic        sys_clk,
  // read port
  input  wire logic        flash_rd,
  input  wire logic [15:0] flash_rd_addr,
  output logic [7:0]       flash_rd_data,
  // program and erase port
  input  wire logic        flash_wr,
  input  wire logic [15:0] flash_wr_addr,
  input  wire logic [7:0]  flash_wr_data,
  input  wire logic        flash_erase,
  output logic             flash_busy
);
  logic [7:0] mem [16'hC000:16'hFFFF];
  logic [2:0] left = 3'h0;
  initial flash_rd_data = 8'h00;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  assign flash_busy = (left != 3'h0);
  always @(posedge sys_clk) begin
    // no strobe means stale data: show its inverse so a late sample is caught
    flash_rd_data <= flash_rd ? mem[flash_rd_addr] : ~flash_rd_data;
    // only chip erase is exercised, so any erase wipes the whole array
    if (flash_erase) foreach (mem[i]) mem[i] <= 8'hFF;
    if (flash_wr) mem[flash_wr_addr] <= flash_wr_data;
    left <= (flash_wr || flash_erase) ? 3'h5 : left - {2'h0, flash_busy};
  end
endmodule
`default_nettype wire

// >>> verif/sfb_handler_asserts.sv
// concurrent checks on the serial boot command handler ports
`timescale 1ns/100ps
`default_nettype none
module sfb_handler_asserts (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       rx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_ready,
  input wire logic [7:0] baud_code,
  input wire logic       read_prot,
  input wire logic       halted,
  input wire logic       flash_busy,
  input wire logic       flash_wr,
  input wire logic       ram_wr,
  input wire logic       flash_erase,
  input wire logic       flash_erase_all,
  input wire logic [3:0] erase_first,
  input wire logic [3:0] erase_last
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_halt_silent: assert property (halted |-> !tx_valid && !rx_ready)
    else $error("halted handler still talks");
  chk_halt_stays: assert property (halted |=> halted)
    else $error("halt left without reset");
  chk_baud_reset: assert property ($fell(sys_rst) |-> baud_code == 8'h28 && !halted)
    else $error("wrong state after reset");
  chk_tx_stands: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte dropped before accept");
  chk_busy_wait: assert property ($past(flash_busy) && flash_busy |-> !rx_ready)
    else $error("byte taken while flash busy");
  chk_erase_prot: assert property (flash_erase && read_prot |-> flash_erase_all)
    else $error("sector erase under protection");
  chk_erase_area: assert property (flash_erase |-> erase_first >= 4'hC
                                   && erase_first <= erase_last)
    else $error("bad erase range");
  chk_prot_block: assert property (read_prot |-> !flash_wr && !ram_wr)
    else $error("write while protected");
  cover property (halted);
  cover property (read_prot);
  cover property (tx_valid && tx_ready && tx_data == 8'hA1);
endmodule
bind sfb_handler sfb_handler_asserts chk (.sys_clk, .sys_rst, .rx_ready, .tx_valid,
  .tx_data, .tx_ready, .baud_code, .read_prot, .halted, .flash_busy, .flash_wr, .ram_wr,
  .flash_erase, .flash_erase_all, .erase_first, .erase_last);
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the serial boot command handler
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0] cmd;
    logic [3:0] len;
    logic [7:0] b0;
    logic [7:0] b1;
  } row_s;
  localparam logic [7:0] ID = 8'h47;  // arbitrary product code
  // all-ones array: 16384 x FFH sums to C000H
  row_s rows [3] = '{'{8'hC0, 4'hD, 8'h3A, ID}, '{8'hC3, 4'h7, 8'h3B, 8'hFF},
                     '{8'h90, 4'h2, 8'hC0, 8'h00}};
  // blank part: password addresses only, one record of 12H at C000H, end record
  logic [7:0]  rec [15] = '{8'hE0, 8'hE0, 8'hE0, 8'hE0, 8'h01, 8'hC0, 8'h00, 8'h00, 8'h12,
                            8'h2D, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF};
  logic        prot_init = 1'b0;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        rx_valid = 1'b0;
  logic        rx_error = 1'b0;
  logic        tx_ready = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic [7:0]  tx_data, baud_code, rd_data, wr_data;
  logic [15:0] rd_addr, wr_addr;
  logic        rx_ready, tx_valid, read_prot, halted, rd, wr, erase, busy;
  int          n_fail = 0;
  int          compares = 0;
  int          k;
  int          j;
  always #5 sys_clk = ~sys_clk;
  flash_model fm (.sys_clk, .flash_rd(rd), .flash_rd_addr(rd_addr), .flash_rd_data(rd_data),
    .flash_wr(wr), .flash_wr_addr(wr_addr), .flash_wr_data(wr_data), .flash_erase(erase),
    .flash_busy(busy));
  sfb_handler #(.ID_CODE(ID)) dut (.sys_clk, .sys_rst, .read_prot_init(prot_init), .rx_valid,
    .rx_data, .rx_error, .rx_ready, .tx_valid, .tx_data, .tx_ready, .baud_code, .read_prot,
    .halted, .flash_rd(rd), .flash_rd_addr(rd_addr), .flash_rd_data(rd_data), .flash_wr(wr),
    .flash_wr_addr(wr_addr), .flash_wr_data(wr_data), .flash_erase(erase),
    .flash_erase_all(), .erase_first(), .erase_last(), .flash_busy(busy), .ram_wr(),
    .ram_addr(), .ram_wr_data(), .jump_valid(), .jump_addr());
  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang();
    n_fail++;
    $display("Error wait ran out");
    give_verdict();
  endtask
  task automatic send(input logic [7:0] b);
    int i;
    i = 0;
    @(posedge sys_clk);
    rx_data <= b;
    rx_valid <= 1'b1;
    do @(negedge sys_clk); while (!rx_ready && ++i < 2000);
    if (i >= 2000) hang();
    @(posedge sys_clk);
    rx_valid <= 1'b0;
  endtask
  task automatic get(input logic [7:0] e, input bit c);
    int i;
    i = 0;
    do @(negedge sys_clk); while (tx_valid !== 1'b1 && ++i < 20000);
    if (i >= 20000) hang();
    if (c) check("tx_data", tx_data, e);
    @(posedge sys_clk);
    tx_ready <= 1'b1;
    @(posedge sys_clk);
    tx_ready <= 1'b0;
  endtask
  task automatic silent();
    logic [7:0] n;
    n = 8'h00;
    repeat (50) begin
      @(negedge sys_clk);
      n += {7'h00, tx_valid};
    end
    check("idle tx_valid count", n, 8'h00);
  endtask
  // reset, an unknown first byte, then the match byte
  task automatic prelude();
    sys_rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check("baud_code", baud_code, 8'h28);
    check("halted", {7'h00, halted}, 8'h00);
    sys_rst <= 1'b0;
    send(8'h11);
    silent();
    send(8'h5A);
    get(8'h5A, 1);
  endtask
  task automatic errs(input logic [7:0] code);
    for (int e = 0; e < 9; e++) get(e < 3 ? 8'hA1 : e < 6 ? 8'hA3 : code, 1);
    repeat (3) @(negedge sys_clk);
    check("halted", {7'h00, halted}, 8'h01);
  endtask
  initial begin
    prelude();
    send(8'h18);
    get(8'h18, 1);
    // the new rate lands at the edge that accepts its echo
    @(negedge sys_clk);
    check("baud_code", baud_code, 8'h18);
    foreach (rows[r]) begin
      send(rows[r].cmd);
      get(rows[r].cmd, 1);
      for (k = 0; k < rows[r].len; k++)
        get(k == 0 ? rows[r].b0 : rows[r].b1, k < 2);
      $display("command %h done", rows[r].cmd);
    end
    send(8'hFA);
    get(8'hFA, 1);
    // protection is set one cycle after the echo is accepted
    repeat (2) @(negedge sys_clk);
    check("read_prot", {7'h00, read_prot}, 8'h01);
    send(8'hC3);
    get(8'hC3, 1);
    for (k = 0; k < 7; k++) get(8'h01, k == 2);
    send(8'h30);
    get(8'h30, 1);
    for (k = 0; k < 100 && !halted; k++) @(negedge sys_clk);
    check("halted", {7'h00, halted}, 8'h01);
    $display("protection test done");
    // strap protection on: chip erase clears it, then write, then erase again
    prot_init <= 1'b1;
    prelude();
    send(8'h28);
    get(8'h28, 1);
    check("read_prot", {7'h00, read_prot}, 8'h01);
    for (k = 0; k < 2; k++) begin
      send(8'hF0);
      get(8'hF0, 1);
      for (j = 0; j < 4; j++) send(rec[j]);
      silent();
      send(8'hCF);
      get(8'hC0, 1);
      get(8'h00, 1);
      check("read_prot", {7'h00, read_prot}, 8'h00);
      if (k == 0) begin
        send(8'h30);
        get(8'h30, 1);
        for (j = 0; j < 15; j++) send(rec[j]);
        get(8'hBF, 1);
        get(8'h13, 1);
      end
    end
    $display("erase and write test done");
    send(8'h55);
    errs(8'h63);
    rx_valid <= 1'b1;
    silent();
    rx_valid <= 1'b0;
    $display("bad command test done");
    prelude();
    send(8'h33);
    errs(8'h62);
    $display("bad baud test done");
    give_verdict();
  end
endmodule
`default_nettype wire
